// ---- shared/rollback_cfg_pkg.sv ----
package rollback_cfg_pkg;

  // =========================================================
  // packet bytes and codes
  localparam logic [7:0] CMD_START_BYTE   = 8'h01;
  localparam logic [7:0] REPLY_START_BYTE = 8'h81;
  localparam logic [7:0] END_BYTE         = 8'h03;
  localparam logic [7:0] CMD_SET          = 8'h4C;
  localparam logic [7:0] CMD_REQ          = 8'h4D;
  localparam logic [7:0] ERR_FLAG         = 8'h80;
  localparam logic [7:0] LEN_HIGH         = 8'h00;
  localparam logic [7:0] LEN_SET          = 8'h05;
  localparam logic [7:0] LEN_REQ          = 8'h01;
  localparam logic [7:0] LEN_STATUS       = 8'h0A;
  localparam logic [7:0] LEN_NONE         = 8'h00;
  localparam logic [7:0] LEN_FALLBACK     = 8'h01;
  localparam logic [7:0] LEN_PAYLOAD_MAX  = 8'h04;
  localparam logic [3:0] TX_STATUS_BYTES  = 4'hF;
  localparam logic [3:0] TX_CFG_BYTES     = 4'hA;

  // =========================================================
  // status codes
  localparam logic [7:0] STS_OK     = 8'h00;
  localparam logic [7:0] STS_PACKET = 8'h01;
  localparam logic [7:0] STS_SUM    = 8'h02;
  localparam logic [7:0] STS_ACCEPT = 8'h03;
  localparam logic [7:0] STS_SECURE = 8'h04;
  localparam logic [7:0] STS_FLASH  = 8'h05;
  localparam logic [31:0] UNUSED_CODE = 32'hFFFF_FFFF;

  // =========================================================
  // configuration storage
  localparam logic [31:0] CFG_ADDR  = 32'h2703_03C0;
  localparam logic [31:0] CFG_RESET = 32'hFFFF_FFFF;
  localparam int BOOT_LOCK_BIT = 5;
  localparam int NS_LOCK_LSB   = 1;
  localparam int S_LOCK_BIT    = 0;
  localparam int NS_SEL_LSB    = 16;
  localparam logic [1:0] AUTH_MIN = 2'h2;

  // =========================================================
  // register map and interrupt bits
  localparam logic [7:0] REG_IRQ_STS = 8'h00;
  localparam logic [7:0] REG_IRQ_MSK = 8'h04;
  localparam logic [7:0] REG_CFG     = 8'h08;
  localparam logic [7:0] REG_LAST    = 8'h0C;
  localparam int IRQ_OK    = 0;
  localparam int IRQ_ERR   = 1;
  localparam int IRQ_FLASH = 2;
  localparam logic [2:0] IRQ_RESET = 3'h0;

  typedef enum logic [3:0] {
    ST_HUNT  = 4'h0,
    ST_LNH   = 4'h1,
    ST_LNL   = 4'h2,
    ST_DATA  = 4'h3,
    ST_SUM   = 4'h4,
    ST_END   = 4'h5,
    ST_CHECK = 4'h6,
    ST_FLASH = 4'h7,
    ST_TX    = 4'h8
  } state_e;

endpackage

// ---- design/rollback_cfg_cmd_handler.sv ----
// Added by the designer: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// (R1) host sends set command: 01, 00 05, 4C, four bytes, sum, 03
// (R2) first received config byte lands at lowest storage address
// (R3) good write replies 81, 00 0A, 4C, 00, unused details and address
// (R4) failure replies 81, 00 0A, CC, one status, details, address; the code sends the command with bit 7 set, so CD for a request
// (R5) bytes other than the start byte are dropped while hunting
// (R6) missing end byte gives packet error
// (R7) wrong checksum gives checksum error
// (R8) length not generic or not command length gives packet error
// (R9) lifecycle refusal gives acceptance error, only after framing passes
// (R10) auth level zero or one gives secure error, nothing written
// (R11) flash write starts only after all checks pass
// (R12) flash fault replies flash error with flash status and address
// (R13) framing and acceptance errors carry the unused code twice
// (R14) first config byte: boot lock bit5, ns locks 4:1, s lock bit0
// (R15) host requests config: 01, 00 01, 4D, sum, 03
// (R16) request answered 81, 00 05, 4D, four bytes lowest first
// (R17) checksum makes byte sum from length high onward zero
module rollback_cfg_cmd_handler
(
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  input  wire logic [7:0]             rx_data,
  input  wire logic                   rx_valid,
  output logic                        rx_ready,
  output logic [7:0]                  tx_data,
  output logic                        tx_valid,
  input  wire logic                   tx_ready,
  input  wire logic                   lifecycle_set_ok,
  input  wire logic                   lifecycle_req_ok,
  input  wire logic [1:0]             auth_level,
  output logic                        flash_req,
  output logic [31:0]                 flash_addr,
  output logic [31:0]                 flash_wdata,
  input  wire logic                   flash_done,
  input  wire logic                   flash_err,
  input  wire logic [31:0]            flash_status,
  input  wire logic [31:0]            flash_fail_addr,
  output logic                        boot_counter_lock,
  output logic [3:0]                  nonsecure_counter_locks,
  output logic                        secure_counter_lock,
  output logic [1:0]                  nonsecure_counter_select,
  input  wire logic [7:0]             avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  output logic [31:0]                 avs_readdata,
  output logic                        avs_waitrequest,
  output logic                        irq
);
  import rollback_cfg_pkg::*;

  typedef struct packed {
    state_e        st;
    logic [7:0]    len;
    logic [7:0]    idx;
    logic          gen_ok;
    logic [7:0]    cmd;
    logic [7:0]    sum;
    logic [31:0]   pay;
    logic          etx_ok;
    logic [31:0]   cfg;
    logic [119:0]  txb;
    logic [3:0]    txn;
    logic          fl_req;
    logic [2:0]    sts;
    logic [2:0]    msk;
    logic [7:0]    last;
    logic          ack;
    logic [31:0]   rdata;
  } core_s;

  core_s s_r;
  core_s s_nxt;

  // =========================================================
  // helpers
  function automatic logic [7:0] cmd_len(input logic [7:0] c);
    cmd_len = (c == CMD_SET) ? LEN_SET :
              (c == CMD_REQ) ? LEN_REQ : LEN_NONE;
  endfunction

  // negated byte sum over a zero padded body
  function automatic logic [7:0] neg_sum(input logic [95:0] b);
    logic [7:0] acc;
    acc = 8'h00;
    for (int i = 0; i < 12; i++)
    begin
      acc = 8'(acc + b[8*i +: 8]);
    end
    neg_sum = 8'(~acc + 8'h01); // (R17)
  endfunction

  // status frame, first byte on the wire in the low bits
  function automatic logic [119:0] sts_frame(
    input logic [7:0]  res,
    input logic [7:0]  code,
    input logic [31:0] det,
    input logic [31:0] adr
  );
    logic [95:0] b;
    b = {adr[7:0], adr[15:8], adr[23:16], adr[31:24],
         det[7:0], det[15:8], det[23:16], det[31:24],
         code, res, LEN_STATUS, LEN_HIGH};
    sts_frame = {END_BYTE, neg_sum(b), b, REPLY_START_BYTE};
  endfunction

  function automatic logic [119:0] cfg_frame(input logic [31:0] d);
    logic [55:0] b;
    b = {d, CMD_REQ, LEN_SET, LEN_HIGH}; // (R16)
    cfg_frame = {40'h00_0000_0000, END_BYTE,
                 neg_sum({40'h00_0000_0000, b}), b, REPLY_START_BYTE};
  endfunction

  logic       rx_take;
  logic [1:0] pay_pos;
  logic       len_ok;
  logic       allowed;
  logic [2:0] ev;
  logic       bus_go;

  assign rx_take = rx_valid && rx_ready;
  assign pay_pos = 2'(s_r.idx - 8'h01);
  assign len_ok  = s_r.len == cmd_len(s_r.cmd); // (R8)
  assign allowed = (s_r.cmd == CMD_SET) ? lifecycle_set_ok
                                        : lifecycle_req_ok;
  assign bus_go  = (avs_read || avs_write) && !s_r.ack;

  // =========================================================
  // next state
  // receive only while framing, so replies and flash stall the link
  always_comb
  begin
    s_nxt = s_r;
    ev = 3'h0;
    unique case (s_r.st)
      ST_HUNT:
      begin
        if (rx_take && rx_data == CMD_START_BYTE) // (R5)
        begin
          s_nxt.st = ST_LNH;
        end
      end
      ST_LNH:
      begin
        if (rx_take)
        begin
          s_nxt.gen_ok = rx_data == LEN_HIGH;
          s_nxt.sum = rx_data;
          s_nxt.st = ST_LNL;
        end
      end
      ST_LNL:
      begin
        if (rx_take)
        begin
          // a bad length still frames one byte so the reply can go out
          s_nxt.gen_ok = s_r.gen_ok && rx_data != LEN_NONE;
          s_nxt.len = s_nxt.gen_ok ? rx_data : LEN_FALLBACK;
          s_nxt.sum = 8'(s_r.sum + rx_data);
          s_nxt.idx = 8'h00;
          s_nxt.st = ST_DATA;
        end
      end
      ST_DATA:
      begin
        if (rx_take)
        begin
          s_nxt.sum = 8'(s_r.sum + rx_data);
          if (s_r.idx == 8'h00)
          begin
            s_nxt.cmd = rx_data; // (R1) (R15)
          end
          else if (s_r.idx <= LEN_PAYLOAD_MAX)
          begin
            s_nxt.pay[{pay_pos, 3'b000} +: 8] = rx_data; // (R2)
          end
          s_nxt.idx = 8'(s_r.idx + 8'h01);
          if (s_nxt.idx == s_r.len)
          begin
            s_nxt.st = ST_SUM;
          end
        end
      end
      ST_SUM:
      begin
        if (rx_take)
        begin
          s_nxt.sum = 8'(s_r.sum + rx_data); // (R17)
          s_nxt.st = ST_END;
        end
      end
      ST_END:
      begin
        if (rx_take)
        begin
          s_nxt.etx_ok = rx_data == END_BYTE;
          s_nxt.st = ST_CHECK;
        end
      end
      ST_CHECK:
      begin
        // only the first failing check is reported
        s_nxt.st = ST_TX;
        s_nxt.txn = TX_STATUS_BYTES;
        s_nxt.last = STS_OK;
        if (!s_r.etx_ok)
        begin
          s_nxt.last = STS_PACKET; // (R6)
        end
        else if (s_r.sum != 8'h00)
        begin
          s_nxt.last = STS_SUM; // (R7)
        end
        else if (!s_r.gen_ok || !len_ok)
        begin
          s_nxt.last = STS_PACKET; // (R8)
        end
        else if (!allowed)
        begin
          s_nxt.last = STS_ACCEPT; // (R9)
        end
        else if (auth_level < AUTH_MIN)
        begin
          s_nxt.last = STS_SECURE; // (R10)
        end
        else if (s_r.cmd == CMD_SET)
        begin
          s_nxt.st = ST_FLASH;
          s_nxt.fl_req = 1'b1; // (R11)
        end
        else
        begin
          s_nxt.txb = cfg_frame(s_r.cfg); // (R16)
          s_nxt.txn = TX_CFG_BYTES;
          ev[IRQ_OK] = 1'b1;
        end
        if (s_nxt.last != STS_OK)
        begin
          s_nxt.txb = sts_frame(s_r.cmd | ERR_FLAG, s_nxt.last,
                                UNUSED_CODE, UNUSED_CODE); // (R4) (R13)
          ev[IRQ_ERR] = 1'b1;
        end
      end
      ST_FLASH:
      begin
        if (flash_done)
        begin
          s_nxt.fl_req = 1'b0;
          s_nxt.st = ST_TX;
          s_nxt.txn = TX_STATUS_BYTES;
          if (flash_err)
          begin
            s_nxt.last = STS_FLASH;
            s_nxt.txb = sts_frame(CMD_SET | ERR_FLAG, STS_FLASH,
                                  flash_status, flash_fail_addr); // (R12)
            ev[IRQ_ERR] = 1'b1;
            ev[IRQ_FLASH] = 1'b1;
          end
          else
          begin
            s_nxt.cfg = s_r.pay;
            s_nxt.txb = sts_frame(CMD_SET, STS_OK,
                                  UNUSED_CODE, UNUSED_CODE); // (R3)
            ev[IRQ_OK] = 1'b1;
          end
        end
      end
      ST_TX:
      begin
        if (tx_ready)
        begin
          s_nxt.txb = s_r.txb >> 8;
          s_nxt.txn = 4'(s_r.txn - 4'h1);
          if (s_r.txn == 4'h1)
          begin
            s_nxt.st = ST_HUNT;
          end
        end
      end
    endcase

    // register slave: one wait cycle, then the answer
    s_nxt.ack = bus_go;
    if (bus_go)
    begin
      unique case (avs_address)
        REG_IRQ_STS: s_nxt.rdata = {29'h0, s_r.sts};
        REG_IRQ_MSK: s_nxt.rdata = {29'h0, s_r.msk};
        REG_CFG:     s_nxt.rdata = s_r.cfg;
        REG_LAST:    s_nxt.rdata = {24'h00_0000, s_r.last};
        default:     s_nxt.rdata = 32'h0000_0000;
      endcase
    end
    // set wins over a write-one clear in the same cycle
    s_nxt.sts = s_r.sts | ev;
    if (s_r.ack && avs_write)
    begin
      if (avs_address == REG_IRQ_STS)
      begin
        s_nxt.sts = (s_r.sts & ~avs_writedata[2:0]) | ev;
      end
      if (avs_address == REG_IRQ_MSK)
      begin
        s_nxt.msk = avs_writedata[2:0];
      end
    end
  end

  // =========================================================
  // state register
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      s_r <= '{st: ST_HUNT, cfg: CFG_RESET, sts: IRQ_RESET,
               msk: IRQ_RESET, default: '0};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // =========================================================
  // outputs
  assign rx_ready = s_r.st inside {ST_HUNT, ST_LNH, ST_LNL, ST_DATA,
                                   ST_SUM, ST_END};
  assign tx_valid = s_r.st == ST_TX;
  assign tx_data = s_r.txb[7:0];
  assign flash_req = s_r.fl_req;
  assign flash_addr = CFG_ADDR;
  assign flash_wdata = s_r.pay; // (R2)
  assign boot_counter_lock = s_r.cfg[BOOT_LOCK_BIT]; // (R14)
  assign nonsecure_counter_locks = s_r.cfg[NS_LOCK_LSB +: 4]; // (R14)
  assign secure_counter_lock = s_r.cfg[S_LOCK_BIT]; // (R14)
  assign nonsecure_counter_select = s_r.cfg[NS_SEL_LSB +: 2];
  assign avs_readdata = s_r.rdata;
  assign avs_waitrequest = (avs_read || avs_write) && !s_r.ack;
  assign irq = |(s_r.sts & s_r.msk);

  // =========================================================
  // checks
  sequence framed_ok;
    s_r.st == ST_CHECK && s_r.etx_ok && s_r.sum == 8'h00 &&
    s_r.gen_ok && len_ok;
  endsequence

  sequence status_is(logic [7:0] code);
    s_r.st == ST_TX && s_r.txb[39:32] == code;
  endsequence

  chk_hunt_discard: assert property ( // (R5)
    @(posedge sys_clk) disable iff (rst)
    s_r.st == ST_HUNT && rx_take && rx_data != CMD_START_BYTE
    |=> s_r.st == ST_HUNT)
    else $error("non start byte left the hunt state");

  chk_end_missing: assert property ( // (R6)
    @(posedge sys_clk) disable iff (rst)
    s_r.st == ST_CHECK && !s_r.etx_ok |=> status_is(STS_PACKET))
    else $error("missing end byte not reported");

  chk_sum_bad: assert property ( // (R7)
    @(posedge sys_clk) disable iff (rst)
    s_r.st == ST_CHECK && s_r.etx_ok && s_r.sum != 8'h00
    |=> status_is(STS_SUM))
    else $error("checksum fault not reported");

  chk_secure_block: assert property ( // (R10)
    @(posedge sys_clk) disable iff (rst)
    framed_ok ##0 allowed && auth_level < AUTH_MIN
    |=> status_is(STS_SECURE) ##0 !flash_req)
    else $error("low auth level not refused");

  chk_write_gate: assert property ( // (R11)
    @(posedge sys_clk) disable iff (rst)
    $rose(flash_req) |-> $past(s_r.st) == ST_CHECK &&
    $past(auth_level) >= AUTH_MIN && $past(allowed))
    else $error("flash write began without passing checks");

  chk_flash_fault: assert property ( // (R12)
    @(posedge sys_clk) disable iff (rst)
    s_r.st == ST_FLASH && flash_done && flash_err
    |=> status_is(STS_FLASH) ##0 s_r.txb[31:24] == 8'hCC)
    else $error("flash fault reply wrong");

  chk_reply_head: assert property ( // (R3)
    @(posedge sys_clk) disable iff (rst)
    $rose(tx_valid) |-> tx_data == REPLY_START_BYTE
    ##1 (tx_data == LEN_HIGH || !$past(tx_ready)))
    else $error("reply does not open with start byte");

  chk_set_wins: assert property ( // set wins over a write-one clear in the same cycle
    @(posedge sys_clk) disable iff (rst)
    ev[IRQ_ERR] && s_r.ack && avs_write &&
    avs_address == REG_IRQ_STS |=> s_r.sts[IRQ_ERR])
    else $error("error event lost under clear");

endmodule

// ---- tb/host_model.sv ----
`timescale 1ns/1ps
// ==========================================================
// host tool on the byte link
module host_model
(
  input  wire logic       sys_clk,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready
);
  logic [7:0] got_q[$];
  logic       slow = 1'b0;

  // idle link at time zero
  initial
  begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b1;
  end

  // offer one byte and hold it until the handler takes it
  task automatic send_byte(input logic [7:0] b);
    @(posedge sys_clk);
    rx_valid <= 1'b1;
    rx_data <= b;
    do @(posedge sys_clk); while (rx_ready !== 1'b1);
    rx_valid <= 1'b0;
    rx_data <= ~b; // released line must not look like a fresh byte
  endtask

  // whole command packet; sum_err spoils the checksum on purpose
  task automatic send_pkt(input logic [7:0] cmd, len,
                          input logic [31:0] d,
                          input logic [7:0] sum_err, endb);
    logic [7:0] s;
    s = len + cmd;
    send_byte(8'h01);
    send_byte(8'h00);
    send_byte(len);
    send_byte(cmd);
    for (int i = 0; i < 4 && i < len - 1; i++)
    begin
      s = s + d[8*i +: 8];
      send_byte(d[8*i +: 8]);
    end
    send_byte(-s + sum_err);
    send_byte(endb);
  endtask

  // collect reply bytes; a slow host stalls every other cycle
  always @(posedge sys_clk)
  begin
    if (tx_valid && tx_ready)
      got_q.push_back(tx_data);
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module testbench;
  import rollback_cfg_pkg::*;
  logic        sys_clk, rst, rx_valid, rx_ready, tx_valid, tx_ready;
  logic        lc_set, lc_req, flash_req, flash_done, flash_err, irq;
  logic        boot_lk, s_lk, avs_read, avs_write, avs_waitrequest;
  logic [1:0]  auth_level, ns_sel;
  logic [3:0]  ns_lk;
  logic [7:0]  rx_data, tx_data, avs_address;
  logic [31:0] flash_addr, flash_wdata, flash_status, fail_addr;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [7:0]  e_q[$];
  int          mismatches = 0;
  int          n_tests = 0;
  int          fl_cnt = 0;
  int          n_writes = 0;

  rollback_cfg_cmd_handler u_dut
  (
    .sys_clk(sys_clk), .rst(rst), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready),
    .lifecycle_set_ok(lc_set), .lifecycle_req_ok(lc_req),
    .auth_level(auth_level), .flash_req(flash_req),
    .flash_addr(flash_addr), .flash_wdata(flash_wdata),
    .flash_done(flash_done), .flash_err(flash_err),
    .flash_status(flash_status), .flash_fail_addr(fail_addr),
    .boot_counter_lock(boot_lk), .nonsecure_counter_locks(ns_lk),
    .secure_counter_lock(s_lk), .nonsecure_counter_select(ns_sel),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq(irq)
  );

  host_model u_host
  (
    .sys_clk(sys_clk), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready)
  );

  // ==========================================================
  // clock, watchdog, flash sequencer
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // every test is a few dozen cycles; this is far beyond them all
  initial
  begin
    #800000;
    mismatches++;
    end_of_test();
  end

  // each write finishes three cycles after the request is seen
  always @(posedge sys_clk)
  begin
    flash_done <= 1'b0;
    if (flash_req && !flash_done)
      fl_cnt <= fl_cnt + 1;
    if (fl_cnt == 3)
    begin
      flash_done <= 1'b1;
      fl_cnt <= 0;
      n_writes++;
    end
  end

  // ==========================================================
  // shared tasks
  task automatic av(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    @(posedge sys_clk);
    avs_read <= ~w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // append checksum and end byte, then compare the collected reply
  task automatic chk_reply();
    logic [7:0] s;
    s = 8'h00;
    foreach (e_q[i])
      if (i > 0)
        s = s + e_q[i];
    e_q.push_back(-s);
    e_q.push_back(8'h03);
    for (int k = 0; k < 4000 && u_host.got_q.size() < e_q.size(); k++)
      @(posedge sys_clk);
    repeat (4) @(posedge sys_clk);
    `CHK("reply length", e_q.size(), u_host.got_q.size())
    foreach (e_q[i])
      `CHK("reply byte", e_q[i], u_host.got_q[i])
    u_host.got_q.delete();
  endtask

  task automatic exp_sts(input logic [7:0] res, sts,
                         input logic [31:0] det, adr);
    e_q = {REPLY_START_BYTE, 8'h00, LEN_STATUS, res, sts};
    for (int i = 3; i >= 0; i--)
      e_q.push_back(det[8*i +: 8]);
    for (int i = 3; i >= 0; i--)
      e_q.push_back(adr[8*i +: 8]);
    chk_reply();
  endtask

  // ==========================================================
  // scenarios
  task automatic t_set_ok();
    u_host.send_byte(8'h55);
    u_host.send_byte(END_BYTE);
    u_host.send_pkt(CMD_SET, LEN_SET, 32'h4432_2211, 8'h00, END_BYTE);
    for (int k = 0; k < 50 && flash_req !== 1'b1; k++)
      @(posedge sys_clk);
    `CHK("flash req", 1'b1, flash_req)
    `CHK("flash data", 32'h4432_2211, flash_wdata)
    `CHK("flash addr", CFG_ADDR, flash_addr)
    exp_sts(CMD_SET, STS_OK, UNUSED_CODE, UNUSED_CODE);
    `CHK("boot lock", 1'b0, boot_lk)
    `CHK("ns locks", 4'h8, ns_lk)
    `CHK("s lock", 1'b1, s_lk)
    `CHK("ns select", 2'h2, ns_sel)
  endtask

  // raise, mask and clear the interrupt; unmapped and read-only places
  task automatic t_irq();
    av(1'b0, REG_IRQ_STS, 32'h0, q);
    `CHK("irq status", 32'h1, q)
    `CHK("irq line", 1'b1, irq)
    av(1'b1, REG_IRQ_MSK, 32'h0, q);
    @(posedge sys_clk);
    `CHK("irq masked", 1'b0, irq)
    av(1'b1, REG_IRQ_MSK, 32'h7, q);
    av(1'b1, REG_IRQ_STS, 32'h1, q);
    @(posedge sys_clk);
    `CHK("irq cleared", 1'b0, irq)
    av(1'b0, 8'h10, 32'h0, q);
    `CHK("unmapped", 32'h0, q)
    av(1'b1, REG_CFG, 32'h0, q);
    av(1'b0, REG_CFG, 32'h0, q);
    `CHK("stored cfg", 32'h4432_2211, q)
  endtask

  // request answered to a host that stalls the reply
  task automatic t_req();
    u_host.slow = 1'b1;
    u_host.send_pkt(CMD_REQ, LEN_REQ, 32'h0, 8'h00, END_BYTE);
    e_q = {REPLY_START_BYTE, 8'h00, LEN_SET, CMD_REQ,
           8'h11, 8'h22, 8'h32, 8'h44};
    chk_reply();
    u_host.slow = 1'b0;
  endtask

  // refused packet: error reply, no flash write
  task automatic t_err(input logic [7:0] cmd, len, se, endb,
                       input logic ls, lr, input logic [1:0] al,
                       input logic [7:0] sts);
    int w0;
    w0 = n_writes;
    lc_set <= ls;
    lc_req <= lr;
    auth_level <= al;
    u_host.send_pkt(cmd, len, 32'hA5A5_A5A5, se, endb);
    exp_sts(cmd | ERR_FLAG, sts, UNUSED_CODE, UNUSED_CODE);
    `CHK("no write", w0, n_writes)
    lc_set <= 1'b1;
    lc_req <= 1'b1;
    auth_level <= 2'h2;
  endtask

  // flash fault carries its status and address
  task automatic t_flash_err();
    // earlier scenarios left ok and error bits standing
    av(1'b1, REG_IRQ_STS, 32'h7, q);
    flash_err <= 1'b1;
    u_host.send_pkt(CMD_SET, LEN_SET, 32'h0, 8'h00, END_BYTE);
    exp_sts(8'hCC, STS_FLASH, flash_status, fail_addr);
    flash_err <= 1'b0;
    av(1'b0, REG_IRQ_STS, 32'h0, q);
    `CHK("irq flash", 32'h6, q)
    av(1'b0, REG_LAST, 32'h0, q);
    `CHK("last status", 32'(STS_FLASH), q)
  endtask

  task automatic end_of_test();
    if (mismatches == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    rst = 1'b1;
    lc_set = 1'b1;
    lc_req = 1'b1;
    auth_level = 2'h2;
    flash_err = 1'b0;
    flash_status = 32'h0000_00A5;
    fail_addr = 32'h2703_03C2;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    av(1'b0, REG_CFG, 32'h0, q);
    `CHK("cfg reset", CFG_RESET, q)
    `CHK("lock reset", CFG_RESET[NS_LOCK_LSB +: 4], ns_lk)
    av(1'b1, REG_IRQ_MSK, 32'h7, q);
    t_set_ok();
    t_irq();
    t_req();
    t_err(CMD_SET, LEN_SET, 8'h00, 8'h55, 1, 1, 2, STS_PACKET);
    t_err(CMD_SET, LEN_SET, 8'h01, END_BYTE, 1, 1, 2, STS_SUM);
    t_err(CMD_SET, 8'h04, 8'h00, END_BYTE, 1, 1, 2, STS_PACKET);
    t_err(CMD_SET, 8'h00, 8'h00, END_BYTE, 1, 1, 2, STS_PACKET);
    t_err(8'h4B, LEN_REQ, 8'h00, END_BYTE, 1, 1, 2, STS_PACKET);
    t_err(CMD_SET, LEN_SET, 8'h00, END_BYTE, 0, 1, 2, STS_ACCEPT);
    t_err(CMD_SET, LEN_SET, 8'h01, END_BYTE, 0, 1, 2, STS_SUM);
    t_err(CMD_SET, LEN_SET, 8'h00, END_BYTE, 1, 1, 1, STS_SECURE);
    t_err(CMD_SET, LEN_SET, 8'h00, END_BYTE, 1, 1, 0, STS_SECURE);
    t_err(CMD_REQ, LEN_REQ, 8'h00, END_BYTE, 1, 0, 2, STS_ACCEPT);
    t_flash_err();
    av(1'b0, REG_CFG, 32'h0, q);
    `CHK("cfg kept", 32'h4432_2211, q)
    end_of_test();
  end
endmodule
